// ---- hdl/bpc_pkg.sv ----
// Purpose: Shared constants and types for the boot pin capture block
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz reference clock
// Notes: Offsets are byte addresses within the device configuration region
package bpc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [31:0] BPC_SNAP_LOW_OFS = 32'h4000_0000;
	localparam logic [31:0] BPC_SNAP_HIGH_OFS = 32'h4000_0004;
	localparam logic [31:0] BPC_HOST_CFG_OFS = 32'h4000_0008;
	localparam logic [31:0] BPC_BOOT_VECTOR = 32'h0000_0000;
	localparam logic [31:0] BPC_DMA0_BASE = 32'h5400_0000;
	localparam logic [31:0] BPC_DMA0_END = 32'h54FF_FFFF;
	localparam logic [31:0] BPC_EMU_BASE = 32'h3000_0000;
	localparam logic [31:0] BPC_EMU_END = 32'h3FFF_FFFF;
	// ----------------------------------------
	// Field positions and resets
	// ----------------------------------------
	localparam int BPC_HOST_CS_BIT = 5;
	localparam int BPC_HCFG_BYTE_BIT = 0;
	localparam int BPC_HCFG_FULL_BIT = 1;
	localparam int BPC_HCFG_HOST_NONMULTIPLEXED_BUS_BIT = 2;
	localparam int BPC_DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_LSB = 24;
	localparam logic [7:0] BPC_SNAP_RESET = 8'h00;
	localparam logic [2:0] BPC_HCFG_RESET = 3'h0;
	localparam logic [1:0] BPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] BPC_RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} bpc_pins_t;
	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} bpc_rd_t;
endpackage : bpc_pkg

// ---- hdl/bpc_top.sv ----
// Purpose: Boot strap pin capture registers behind an AXI4-Lite slave
// Assumes: Pins are static around reset release; emulator/watchdog resets arrive separately
// Notes: Also decodes audio DMA window and dynamic memory config top-byte writes
//
// Contract
// - After reset instruction fetch starts only at internal ROM address zero.
// - External reset rising edge latches eight pins into low capture bits 7:0.
// - Same edge latches eight pins into high capture, host select at bit 5.
// - Capture bits 31:8 reserved; read zero, software writes zeros.
// - Capture registers reload only on external reset apply and release.
// - Emulator or watchdog reset leaves both capture registers unchanged.
// - Host select low at reset copies three serial pins into host config.
// - Any word address in the audio DMA window reaches its data path; code hits only when all four DMA_STRB_IN lanes are set.
// - Top byte of dynamic memory config accepts byte writes.
//
// The AXI4-Lite slave port was chosen for this implementation.
module bpc_top import bpc_pkg::*; (
	// Clock, reset, enable
	input wire logic REF_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CLK_EN_IN,
	input wire logic SOFT_RESET_IN,
	// Boot strap pins
	input wire logic [15:0] BOOT_PINS_IN,
	// Address screening
	input wire logic [31:0] FETCH_ADDR_IN,
	input wire logic [31:0] DMA_ADDR_IN,
	input wire logic [3:0] DMA_STRB_IN,
	output logic FETCH_ALLOWED_OUT,
	output logic DMA_HIT_OUT,
	output logic DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_WE_OUT,
	output logic [7:0] DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_DATA_OUT,
	output logic [2:0] HOST_CFG_OUT,
	output logic BOOT_DONE_OUT,
	// AXI4-Lite slave
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// ----------------------------------------
	// Pin synchroniser and capture
	// ----------------------------------------
	logic [15:0] pin_s1_r, pin_s2_r;
	logic armed_r, armed_nxt;
	logic [1:0] settle_r, settle_nxt;
	bpc_pins_t snap_r, snap_nxt;
	logic [2:0] hcfg_r, hcfg_nxt;

	// Capture runs on the third enabled edge after release; soft reset only stalls the settle count before it
	always_comb begin
		armed_nxt = armed_r;
		snap_nxt = snap_r;
		hcfg_nxt = hcfg_r;
		// Synchroniser holds reset zeros for two edges after release
		if (armed_r && settle_r == 2'h2) begin
			armed_nxt = 1'b0;
			snap_nxt.low = pin_s2_r[7:0];
			snap_nxt.high = pin_s2_r[15:8];
			if (!pin_s2_r[8 + BPC_HOST_CS_BIT]) begin
				hcfg_nxt[BPC_HCFG_BYTE_BIT] = pin_s2_r[7];
				hcfg_nxt[BPC_HCFG_FULL_BIT] = pin_s2_r[6];
				hcfg_nxt[BPC_HCFG_HOST_NONMULTIPLEXED_BUS_BIT] = pin_s2_r[5];
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			pin_s1_r <= 16'h0000;
			pin_s2_r <= 16'h0000;
			armed_r <= 1'b1;
			snap_r <= {BPC_SNAP_RESET, BPC_SNAP_RESET};
			hcfg_r <= BPC_HCFG_RESET;
		end else if (CLK_EN_IN) begin
			pin_s1_r <= BOOT_PINS_IN;
			pin_s2_r <= pin_s1_r;
			armed_r <= armed_nxt;
			snap_r <= snap_nxt;
			hcfg_r <= hcfg_nxt;
		end
	end

	// Capture waits two edges so the synchroniser holds real pin levels
	always_comb begin
		settle_nxt = settle_r;
		if (settle_r != 2'h3) begin
			settle_nxt = settle_r + 2'h1;
		end
	end
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			settle_r <= 2'h0;
		end else if (CLK_EN_IN && !SOFT_RESET_IN) begin
			settle_r <= settle_nxt;
		end
	end
	// ----------------------------------------
	// Address screening
	// ----------------------------------------
	always_comb begin
		FETCH_ALLOWED_OUT = (FETCH_ADDR_IN == BPC_BOOT_VECTOR) || !armed_r;
		DMA_HIT_OUT = (DMA_ADDR_IN >= BPC_DMA0_BASE) && (DMA_ADDR_IN <= BPC_DMA0_END)
			&& (DMA_STRB_IN == 4'hF);
		BOOT_DONE_OUT = !armed_r;
		HOST_CFG_OUT = hcfg_r;
	end
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
	logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	bpc_rd_t rd_r, rd_nxt;
	logic sdwe_r, sdwe_nxt;
	logic [7:0] sdd_r, sdd_nxt;

	function automatic logic [31:0] bpc_read(input logic [31:0] a, input bpc_pins_t s, input logic [2:0] h);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a[31:2] == BPC_SNAP_LOW_OFS[31:2]) v = {24'h000000, s.low};
		if (a[31:2] == BPC_SNAP_HIGH_OFS[31:2]) v = {24'h000000, s.high};
		if (a[31:2] == BPC_HOST_CFG_OFS[31:2]) v = {29'h00000000, h};
		return v;
	endfunction : bpc_read

	always_comb begin
		aw_nxt = aw_r;
		w_nxt = w_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		b_nxt = b_r;
		bresp_nxt = bresp_r;
		r_nxt = r_r;
		rd_nxt = rd_r;
		sdwe_nxt = 1'b0;
		sdd_nxt = sdd_r;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_nxt = 1'b1;
			awa_nxt = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_nxt = 1'b1;
			wd_nxt = S_AXI_WDATA;
			ws_nxt = S_AXI_WSTRB;
		end
		if (aw_r && w_r && !b_r) begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			b_nxt = 1'b1;
			bresp_nxt = BPC_RESP_OKAY;
			// Capture and config words are read-only; writes are dropped silently
			if (awa_r[31:2] == BPC_SNAP_LOW_OFS[31:2] || awa_r[31:2] == BPC_SNAP_HIGH_OFS[31:2]
				|| awa_r[31:2] == BPC_HOST_CFG_OFS[31:2]) begin
				bresp_nxt = BPC_RESP_OKAY;
			end else if (ws_r[3]) begin
				sdwe_nxt = 1'b1;
				sdd_nxt = wd_r[BPC_DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_LSB +: 8];
			end else begin
				bresp_nxt = BPC_RESP_SLVERR;
			end
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			b_nxt = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			r_nxt = 1'b1;
			rd_nxt.data = bpc_read(S_AXI_ARADDR, snap_r, hcfg_r);
			rd_nxt.resp = (S_AXI_ARADDR[31:2] == BPC_SNAP_LOW_OFS[31:2]
				|| S_AXI_ARADDR[31:2] == BPC_SNAP_HIGH_OFS[31:2]
				|| S_AXI_ARADDR[31:2] == BPC_HOST_CFG_OFS[31:2]) ? BPC_RESP_OKAY : BPC_RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			r_nxt = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			b_r <= 1'b0;
			r_r <= 1'b0;
			awa_r <= 32'h0000_0000;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			bresp_r <= BPC_RESP_OKAY;
			rd_r <= '0;
			sdwe_r <= 1'b0;
			sdd_r <= 8'h00;
		end else if (CLK_EN_IN) begin
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			b_r <= b_nxt;
			r_r <= r_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			bresp_r <= bresp_nxt;
			rd_r <= rd_nxt;
			sdwe_r <= sdwe_nxt;
			sdd_r <= sdd_nxt;
		end
	end

	// Ready only when enabled so a frozen block never takes a beat
	always_comb begin
		S_AXI_AWREADY = CLK_EN_IN && !aw_r && !b_r;
		S_AXI_WREADY = CLK_EN_IN && !w_r && !b_r;
		S_AXI_BVALID = b_r;
		S_AXI_BRESP = bresp_r;
		S_AXI_ARREADY = CLK_EN_IN && !r_r;
		S_AXI_RVALID = r_r;
		S_AXI_RDATA = rd_r.data;
		S_AXI_RRESP = rd_r.resp;
		DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_WE_OUT = sdwe_r;
		DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_DATA_OUT = sdd_r;
	end
endmodule : bpc_top

// ---- tb/bpc_checker.sv ----
// Purpose: Port assertions for the boot pin capture block
// Assumes: Bound to bpc_top; pins are static around reset release
// Notes: Ports grouped per line to stay compact
module bpc_checker import bpc_pkg::*; (
	// Clock, reset, pins
	input wire logic REF_CLK_IN, RESET_N_IN,
	input wire logic [15:0] BOOT_PINS_IN,
	// Screening
	input wire logic [31:0] FETCH_ADDR_IN, DMA_ADDR_IN,
	input wire logic [3:0] DMA_STRB_IN,
	input wire logic FETCH_ALLOWED_OUT, DMA_HIT_OUT, DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_WE_OUT, BOOT_DONE_OUT,
	input wire logic [2:0] HOST_CFG_OUT,
	// Register bus
	input wire logic [31:0] S_AXI_ARADDR, S_AXI_RDATA,
	input wire logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_BVALID,
	input wire logic [1:0] S_AXI_BRESP
);
	// ----------------------------------------
	// Pin image, frozen once capture is done
	// ----------------------------------------
	logic [15:0] snap_r;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
		if (!RESET_N_IN) snap_r <= 16'h0000;
		else if (!BOOT_DONE_OUT) snap_r <= BOOT_PINS_IN;
	property p_fetch; FETCH_ALLOWED_OUT == (FETCH_ADDR_IN == 32'h0 || BOOT_DONE_OUT); endproperty
	a_fetch: assert property (p_fetch) else $error("fetch gate wrong");
	property p_lo; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == BPC_SNAP_LOW_OFS
		|=> S_AXI_RVALID && S_AXI_RDATA == {24'h000000, snap_r[7:0]}; endproperty
	a_lo: assert property (p_lo) else $error("low snapshot wrong");
	property p_hi; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == BPC_SNAP_HIGH_OFS
		|=> S_AXI_RVALID && S_AXI_RDATA == {24'h000000, snap_r[15:8]}; endproperty
	a_hi: assert property (p_hi) else $error("high snapshot wrong");
	property p_done; BOOT_DONE_OUT |=> BOOT_DONE_OUT; endproperty
	a_done: assert property (p_done) else $error("capture re-armed");
	property p_keep; BOOT_DONE_OUT && $past(BOOT_DONE_OUT) |-> $stable(HOST_CFG_OUT); endproperty
	a_keep: assert property (p_keep) else $error("host config changed");
	property p_cfg; $rose(BOOT_DONE_OUT) && !BOOT_PINS_IN[13]
		|-> HOST_CFG_OUT == {BOOT_PINS_IN[5], BOOT_PINS_IN[6], BOOT_PINS_IN[7]}; endproperty
	a_cfg: assert property (p_cfg) else $error("host config copy wrong");
	property p_dma; DMA_HIT_OUT == (DMA_ADDR_IN[31:24] == 8'h54 && DMA_STRB_IN == 4'hF); endproperty
	a_dma: assert property (p_dma) else $error("dma window decode wrong");
	property p_dynamic_memory_config_register; DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_WE_OUT |-> S_AXI_BVALID && S_AXI_BRESP == BPC_RESP_OKAY; endproperty
	a_dynamic_memory_config_register: assert property (p_dynamic_memory_config_register) else $error("top byte write without okay");
	c_dynamic_memory_config_register: cover property (DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_WE_OUT);
	c_host: cover property ($rose(BOOT_DONE_OUT) && !BOOT_PINS_IN[13]);
	c_dma: cover property (DMA_HIT_OUT);
endmodule : bpc_checker

// ---- tb/bpc_strap_model.sv ----
// Purpose: Board strapping that selects a boot mode
// Assumes: Mode 0 host, 1..5 flash, serial master/slave, two-wire master/slave
// Notes: Pins outside the mode keep free_in
module bpc_strap_model (
	input wire logic [2:0] mode_in,
	input wire logic [15:0] free_in,
	output logic [15:0] pins_out
);
	logic [3:0] st;
	always_comb begin
		case (mode_in)
			3'h1: st = 4'hA;
			3'h2: st = 4'h9;
			3'h3: st = 4'hB;
			3'h4: st = 4'hD;
			3'h5: st = 4'hF;
			default: st = {1'b0, free_in[7:5]};
		endcase
		pins_out = free_in;
		{pins_out[13], pins_out[7:5]} = st;
	end
endmodule : bpc_strap_model

// ---- tb/bpc_top_bench.sv ----
// Purpose: Self-checking bench for bpc_top
// Assumes: Bus tasks start one edge after entry
// Notes: Each mode is a full external reset
module bpc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import bpc_pkg::*;
	logic REF_CLK_IN = 0, RESET_N_IN = 0, CLK_EN_IN = 1, SOFT_RESET_IN = 0;
	logic [31:0] FETCH_ADDR_IN = 0, DMA_ADDR_IN = 0, S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0;
	logic [3:0] DMA_STRB_IN = 0, S_AXI_WSTRB = 0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic FETCH_ALLOWED_OUT, DMA_HIT_OUT, DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_WE_OUT, BOOT_DONE_OUT, S_AXI_AWREADY, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [7:0] DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_DATA_OUT;
	logic [2:0] HOST_CFG_OUT, mode = 0;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	logic [31:0] S_AXI_RDATA, d, a;
	logic [15:0] BOOT_PINS_IN, noise = 0;
	int mismatches = 0, checked = 0;
	always #25 REF_CLK_IN = ~REF_CLK_IN;
	bpc_top i_dut (.*);
	bpc_strap_model i_strap (.mode_in(mode), .free_in(noise), .pins_out(BOOT_PINS_IN));
	task automatic chk(input string w, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [31:0] aa, dd, input logic [3:0] s);
		int n;
		@(posedge REF_CLK_IN);
		{S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB} <= {aa, dd, s};
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		for (n = 0; n < 40 && S_AXI_BVALID !== 1'b1; n++) begin
			@(posedge REF_CLK_IN);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 0;
		end
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 0;
		if (n == 40) begin mismatches++; print_verdict(); end
	endtask : wr
	task automatic rd(input logic [31:0] aa);
		int n;
		@(posedge REF_CLK_IN);
		{S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {aa, 2'h3};
		for (n = 0; n < 40 && S_AXI_RVALID !== 1'b1; n++) begin
			@(posedge REF_CLK_IN);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 0;
		end
		{d, r} = {S_AXI_RDATA, S_AXI_RRESP};
		S_AXI_RREADY <= 0;
		if (n == 40) begin mismatches++; print_verdict(); end
	endtask : rd
	task automatic boot(input logic [2:0] m);
		int n;
		logic [15:0] p;
		@(posedge REF_CLK_IN);
		{RESET_N_IN, mode, noise, FETCH_ADDR_IN} <= {1'b0, m, 16'($urandom), 32'h4};
		repeat (20) @(posedge REF_CLK_IN);
		chk("fetch in reset", 0, FETCH_ALLOWED_OUT);
		RESET_N_IN <= 1;
		for (n = 0; n < 20 && BOOT_DONE_OUT !== 1'b1; n++) @(posedge REF_CLK_IN);
		if (n == 20) begin mismatches++; print_verdict(); end
		p = BOOT_PINS_IN;
		chk("fetch after boot", 1, FETCH_ALLOWED_OUT);
		rd(BPC_SNAP_LOW_OFS); chk("low", {24'h000000, p[7:0]}, d);
		rd(BPC_SNAP_HIGH_OFS); chk("high", {24'h000000, p[15:8]}, d);
		chk("host cfg", p[13] ? 32'h0 : {29'h0, p[5], p[6], p[7]}, {29'h0, HOST_CFG_OUT});
		wr(BPC_SNAP_LOW_OFS, {24'h000000, ~p[7:0]}, 4'hF); chk("ro resp", BPC_RESP_OKAY, r);
		{SOFT_RESET_IN, noise} <= {1'b1, ~noise};
		repeat (3) @(posedge REF_CLK_IN);
		SOFT_RESET_IN <= 0;
		rd(BPC_SNAP_LOW_OFS); chk("low kept", {24'h000000, p[7:0]}, d);
		rd(BPC_SNAP_HIGH_OFS); chk("high kept", {24'h000000, p[15:8]}, d);
	endtask : boot
	initial begin
		void'($urandom(32'hABABBF8F));
		for (int m = 0; m < 6; m++) boot(3'(m));
		// Word-aligned addresses in the 0xF000_0000 region, outside the capture and config words
		for (int i = 0; i < 4; i++) begin
			a = 32'hF000_0000 | ((32'($urandom) % 48) << 2);
			d = $urandom;
			wr(a, d, 4'h8); chk("top resp", BPC_RESP_OKAY, r);
			chk("top data", {24'h000000, d[31:24]}, {24'h000000, DYNAMIC_MEMORY_CONFIG_REGISTER_TOP_DATA_OUT});
		end
		wr(32'hF000_0000, 32'h0, 4'h7); chk("lane resp", BPC_RESP_SLVERR, r);
		rd(32'h4000_0010); chk("unmapped resp", {30'h0, BPC_RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		for (int i = 0; i < 6; i++) begin
			@(posedge REF_CLK_IN);
			a = (i < 4) ? {8'h54, 24'($urandom)} : 32'h5500_0000 - 32'(i - 4);
			{DMA_ADDR_IN, DMA_STRB_IN} <= {a, (i == 1) ? 4'h1 : 4'hF};
			@(posedge REF_CLK_IN);
			chk("dma hit", {31'h0, i != 1 && i != 4}, {31'h0, DMA_HIT_OUT});
		end
		print_verdict();
	end
endmodule : bpc_top_bench
bind bpc_top bpc_checker i_chk (.*);
